// *** include/ppt_pkg.sv ***
// constants and types shared by the perf/power/tx-timer/rom-port register bank
package ppt_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_PERF       = 8'h8c;
  localparam logic [7:0] OFF_TXBR       = 8'h9c;
  localparam logic [7:0] OFF_ROM        = 8'ha0;
  localparam logic [7:0] OFF_POWER_MGMT_CTRL_STATUS_MIRROR      = 8'he0;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'he4;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'he8;
  localparam logic [7:0] OFF_CTRL       = 8'hec;

  // performance counter fields
  localparam int PERF_CLK_LSB  = 16;
  localparam int PERF_DW_LSB   = 0;

  // power management word fields
  localparam int PM_WAKE_BIT   = 15;
  localparam int PM_SCALE_LSB  = 13;
  localparam int PM_SEL_LSB    = 9;
  localparam int PM_WEN_BIT    = 8;
  localparam int PM_PS_LSB     = 0;
  localparam logic [1:0] PS_RESET = 2'h0;

  // transmit burst / time-out fields
  localparam int TX_THR_LSB    = 16;
  localparam int TX_TTO_LSB    = 0;
  localparam logic [4:0]  TX_THR_RESET = 5'h00;
  localparam logic [11:0] TX_TTO_RESET = 12'h000;

  // rom port fields
  localparam int ROM_A16_BIT   = 31;
  localparam int ROM_REN_BIT   = 27;
  localparam int ROM_WEN_BIT   = 26;
  localparam int ROM_ADDR_LSB  = 8;
  localparam int ROM_DATA_LSB  = 0;
  localparam logic ROM_A16_RESET = 1'b1;

  // interrupt status bits
  localparam int IRQ_WAKE      = 0;
  localparam int IRQ_TX_DONE   = 1;
  localparam int IRQ_TX_IDLE   = 2;
  localparam int IRQ_ROM_DONE  = 3;
  localparam int IRQ_N         = 4;

  // control register bits
  localparam int CTRL_TX_IDLE_IRQ_ENABLE_BIT = 0;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_100_NS   = 2560;
  localparam int TICK_10_NS    = 25500;
  localparam int TICK_100_CYC  = TICK_100_NS / CLK_PERIOD_NS;
  localparam int TICK_10_CYC   = TICK_10_NS / CLK_PERIOD_NS;
  localparam int ROM_ACC_NS    = 200;
  localparam int ROM_ACC_CYC   = (ROM_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROM_SETUP_CYC = 2;

  typedef enum logic [1:0] {
    FL_IDLE   = 2'b00,
    FL_SETUP  = 2'b01,
    FL_STROBE = 2'b10,
    FL_HOLD   = 2'b11
  } ppt_flash_st_t;
endpackage : ppt_pkg

// *** logic/ppt_flash_port.sv ***
// byte-wide flash / boot rom access sequencer
`timescale 1ns/1ps
module ppt_flash_port #(
  parameter int ACC_CYC = ppt_pkg::ROM_ACC_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // request side
  input  wire logic        start_rd,
  input  wire logic        start_wr,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdata_q,
  // flash pins
  output logic [16:0]      rom_addr_o,
  output logic             rom_ce_n_o,
  output logic             rom_oe_n_o,
  output logic             rom_we_n_o,
  input  wire logic [7:0]  rom_data_i,
  output logic [7:0]       rom_data_o,
  output logic             rom_data_oe_n_o
);
  ppt_pkg::ppt_flash_st_t st_q;
  logic [7:0]  cnt_q;
  logic        wr_q;
  logic [7:0]  din_s1_q;
  logic [7:0]  din_s2_q;

  assign busy = (st_q != ppt_pkg::FL_IDLE);

  // pin data synchroniser
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= rom_data_i;
      din_s2_q <= din_s1_q;
    end
  end

  // access sequence
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q            <= ppt_pkg::FL_IDLE;
      cnt_q           <= 8'h00;
      wr_q            <= 1'b0;
      done            <= 1'b0;
      rdata_q         <= 8'h00;
      rom_addr_o      <= 17'h00000;
      rom_ce_n_o      <= 1'b1;
      rom_oe_n_o      <= 1'b1;
      rom_we_n_o      <= 1'b1;
      rom_data_o      <= 8'h00;
      rom_data_oe_n_o <= 1'b1;
    end else begin
      done <= 1'b0;
      unique case (st_q)
        ppt_pkg::FL_IDLE: begin
          if (start_rd || start_wr) begin
            wr_q            <= start_wr && !start_rd;
            rom_addr_o      <= addr;
            rom_data_o      <= wdata;
            rom_data_oe_n_o <= !(start_wr && !start_rd);
            rom_ce_n_o      <= 1'b0;
            cnt_q           <= 8'(ppt_pkg::ROM_SETUP_CYC);
            st_q            <= ppt_pkg::FL_SETUP;
          end
        end
        ppt_pkg::FL_SETUP: begin
          if (cnt_q <= 8'h01) begin
            rom_oe_n_o <= wr_q;
            rom_we_n_o <= !wr_q;
            cnt_q      <= 8'(ACC_CYC);
            st_q       <= ppt_pkg::FL_STROBE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ppt_pkg::FL_STROBE: begin
          if (cnt_q <= 8'h01) begin
            if (!wr_q) begin
              rdata_q <= din_s2_q;
            end
            rom_oe_n_o <= 1'b1;
            rom_we_n_o <= 1'b1;
            st_q       <= ppt_pkg::FL_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ppt_pkg::FL_HOLD: begin
          rom_ce_n_o      <= 1'b1;
          rom_data_oe_n_o <= 1'b1;
          done            <= 1'b1;
          st_q            <= ppt_pkg::FL_IDLE;
        end
      endcase
    end
  end
endmodule : ppt_flash_port

// *** logic/ppt_csr_bank.sv ***
// host register bank: perf counter, power word, tx burst/time-out, boot rom port
`timescale 1ns/1ps
// Behaviour
// - the high half of the perf counter adds up clocks from each master read request to its completion.
// - the low byte of the perf counter adds up double words moved by all master transactions.
// - both perf fields are read only; each read of that register subtracts the value it returned, so counts since that value was sampled remain.
// - the wake status flag sets on any wake event whatever the wake signal enable.
// - writing one to the wake status flag clears it and releases the wake pin; writing zero does nothing.
// - the power data scale field always reads zero.
// - the power data select field always reads zero.
// - the power state field reports and takes the state, 00 D0, 01 D1, 10 D2, 11 D3hot.
// - a write of an unsupported power state completes on the bus but leaves the state unchanged.
// - the tx burst threshold sets how many consecutive good bursts raise the tx completed interrupt.
// - while tx idle interrupt enable is set the time-out counts down in 2.56us or 25.5us steps by speed.
// - a time-out reaching zero before the next packet starts raises the tx idle interrupt.
// - the address-16 select bit only acts in four-led mode, routing the shared pin to rom address 16.
// - a rom read is started with address and read enable, which clears when the byte is ready.
// - a rom write is started with write enable, which clears when the flash write is done.
// - four-led mode comes from a configuration input, clear for three leds and set for four.
module ppt_csr_bank #(
  parameter logic [3:0] PS_SUPPORTED = 4'h9,
  parameter int         ADDR_W       = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // bus master activity
  input  wire logic              bm_rd_pending,
  input  wire logic              bm_dword,
  // wake and power
  input  wire logic              wake_event,
  output logic                   pme_o,
  output logic                   pme_oe_n_o,
  output logic [1:0]             power_state_o,
  // transmit activity
  input  wire logic              speed_100,
  input  wire logic              tx_burst_ok,
  input  wire logic              tx_burst_fail,
  input  wire logic              tx_pkt_start,
  input  wire logic              tx_pkt_end,
  // led / rom pin sharing
  input  wire logic              four_led_select,
  input  wire logic              led_fd_col,
  output logic                   shared_pin_o,
  // flash pins
  output logic [16:0]            rom_addr_o,
  output logic                   rom_ce_n_o,
  output logic                   rom_oe_n_o,
  output logic                   rom_we_n_o,
  input  wire logic [7:0]        rom_data_i,
  output logic [7:0]             rom_data_o,
  output logic                   rom_data_oe_n_o,
  // interrupt
  output logic                   irq_o
);
  // byte enables as a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : sel_mask

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a[7:0] == off);
  endfunction : hit

  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rd_mux;
  logic        commit;
  logic        wr_c;
  logic        rd_c;
  logic [31:0] wmask;
  logic [31:0] wd;

  logic [15:0] perf_clk_q;
  logic [7:0]  perf_dw_q;
  logic        wake_q;
  logic        wake_en_q;
  logic [1:0]  ps_q;
  logic [4:0]  tx_thr_q;
  logic [11:0] tx_tto_q;
  logic        tx_idle_irq_enable_q;
  logic        a16_sel_q;
  logic        ren_q;
  logic        wen_q;
  logic [16:0] rom_addr_q;
  logic [7:0]  rom_wdat_q;
  localparam int IRQ_N_W = ppt_pkg::IRQ_N;
  logic [IRQ_N_W-1:0] irq_stat_q;
  logic [IRQ_N_W-1:0] irq_mask_q;
  logic [IRQ_N_W-1:0] irq_set;

  logic        led_s1_q;
  logic        led_s2_q;
  logic [4:0]  burst_run_q;
  logic        tx_done_ev;
  logic [11:0] tick_cnt_q;
  logic        tick;
  logic [11:0] tto_cnt_q;
  logic        tto_arm_q;
  logic        tx_idle_ev;
  logic        fl_busy;
  logic        fl_done;
  logic [7:0]  fl_rdata;
  logic        start_rd;
  logic        start_wr;
  logic [1:0]  ps_new;

  // wishbone: ack one cycle after the request, effects at the ack edge
  assign commit   = wb_cyc_i && wb_stb_i && ack_q;
  assign wr_c     = commit && wb_we_i;
  assign rd_c     = commit && !wb_we_i;
  assign wmask    = sel_mask(wb_sel_i);
  assign wd       = wb_dat_i & wmask;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        rdat_q <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit(wb_adr_i, ppt_pkg::OFF_PERF)) begin
      rd_mux[ppt_pkg::PERF_CLK_LSB +: 16] = perf_clk_q;
      rd_mux[ppt_pkg::PERF_DW_LSB +: 8]   = perf_dw_q;
    end else if (hit(wb_adr_i, ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR)) begin
      rd_mux[ppt_pkg::PM_WAKE_BIT]        = wake_q;
      rd_mux[ppt_pkg::PM_SCALE_LSB +: 2]  = 2'h0;
      rd_mux[ppt_pkg::PM_SEL_LSB +: 4]    = 4'h0;
      rd_mux[ppt_pkg::PM_WEN_BIT]         = wake_en_q;
      rd_mux[ppt_pkg::PM_PS_LSB +: 2]     = ps_q;
    end else if (hit(wb_adr_i, ppt_pkg::OFF_TXBR)) begin
      rd_mux[ppt_pkg::TX_THR_LSB +: 5]    = tx_thr_q;
      rd_mux[ppt_pkg::TX_TTO_LSB +: 12]   = tx_tto_q;
    end else if (hit(wb_adr_i, ppt_pkg::OFF_ROM)) begin
      rd_mux[ppt_pkg::ROM_A16_BIT]        = a16_sel_q;
      rd_mux[ppt_pkg::ROM_REN_BIT]        = ren_q;
      rd_mux[ppt_pkg::ROM_WEN_BIT]        = wen_q;
      rd_mux[ppt_pkg::ROM_ADDR_LSB +: 17] = rom_addr_q;
      rd_mux[ppt_pkg::ROM_DATA_LSB +: 8]  = rom_wdat_q;
    end else if (hit(wb_adr_i, ppt_pkg::OFF_IRQ_STAT)) begin
      rd_mux[IRQ_N_W-1:0]                 = irq_stat_q;
    end else if (hit(wb_adr_i, ppt_pkg::OFF_IRQ_MASK)) begin
      rd_mux[IRQ_N_W-1:0]                 = irq_mask_q;
    end else if (hit(wb_adr_i, ppt_pkg::OFF_CTRL)) begin
      rd_mux[ppt_pkg::CTRL_TX_IDLE_IRQ_ENABLE_BIT]      = tx_idle_irq_enable_q;
    end
  end

  // perf counter; a read subtracts what it returned so nothing is lost
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      perf_clk_q <= 16'h0000;
      perf_dw_q  <= 8'h00;
    end else begin
      if (rd_c && hit(wb_adr_i, ppt_pkg::OFF_PERF)) begin
        perf_clk_q <= perf_clk_q - rdat_q[ppt_pkg::PERF_CLK_LSB +: 16] + {15'h0000, bm_rd_pending};
        perf_dw_q  <= perf_dw_q - rdat_q[ppt_pkg::PERF_DW_LSB +: 8] + {7'h00, bm_dword};
      end else begin
        perf_clk_q <= perf_clk_q + {15'h0000, bm_rd_pending};
        perf_dw_q  <= perf_dw_q + {7'h00, bm_dword};
      end
    end
  end

  // power management word
  assign ps_new = wd[ppt_pkg::PM_PS_LSB +: 2];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_q    <= 1'b0;
      wake_en_q <= 1'b0;
      ps_q      <= ppt_pkg::PS_RESET;
    end else begin
      if (wake_event) begin
        wake_q <= 1'b1;
      end else if (wr_c && hit(wb_adr_i, ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR) && wd[ppt_pkg::PM_WAKE_BIT]) begin
        wake_q <= 1'b0;
      end
      if (wr_c && hit(wb_adr_i, ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR)) begin
        if (wmask[ppt_pkg::PM_WEN_BIT]) begin
          wake_en_q <= wd[ppt_pkg::PM_WEN_BIT];
        end
        if (wmask[ppt_pkg::PM_PS_LSB] && PS_SUPPORTED[ps_new]) begin
          ps_q <= ps_new;
        end
      end
    end
  end

  assign pme_o         = 1'b0;
  assign pme_oe_n_o    = !(wake_q && wake_en_q);
  assign power_state_o = ps_q;

  // tx burst threshold, time-out value and idle enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_thr_q <= ppt_pkg::TX_THR_RESET;
      tx_tto_q <= ppt_pkg::TX_TTO_RESET;
      tx_idle_irq_enable_q   <= 1'b0;
    end else if (wr_c) begin
      if (hit(wb_adr_i, ppt_pkg::OFF_TXBR)) begin
        tx_thr_q <= (tx_thr_q & ~wmask[ppt_pkg::TX_THR_LSB +: 5]) | wd[ppt_pkg::TX_THR_LSB +: 5];
        tx_tto_q <= (tx_tto_q & ~wmask[ppt_pkg::TX_TTO_LSB +: 12]) | wd[ppt_pkg::TX_TTO_LSB +: 12];
      end
      if (hit(wb_adr_i, ppt_pkg::OFF_CTRL) && wmask[ppt_pkg::CTRL_TX_IDLE_IRQ_ENABLE_BIT]) begin
        tx_idle_irq_enable_q <= wd[ppt_pkg::CTRL_TX_IDLE_IRQ_ENABLE_BIT];
      end
    end
  end

  // consecutive good bursts
  assign tx_done_ev = tx_burst_ok && ((burst_run_q + 5'h01) >= tx_thr_q);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      burst_run_q <= 5'h00;
    end else if (tx_burst_fail || tx_done_ev) begin
      burst_run_q <= 5'h00;
    end else if (tx_burst_ok) begin
      burst_run_q <= burst_run_q + 5'h01;
    end
  end

  // time-out step divider
  assign tick = tx_idle_irq_enable_q && (tick_cnt_q == 12'h000);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= 12'h000;
    end else if (!tx_idle_irq_enable_q || tick_cnt_q == 12'h000) begin
      tick_cnt_q <= speed_100 ? 12'(ppt_pkg::TICK_100_CYC - 1) : 12'(ppt_pkg::TICK_10_CYC - 1);
    end else begin
      tick_cnt_q <= tick_cnt_q - 12'h001;
    end
  end

  // idle timer armed at packet end, cancelled by the next start
  assign tx_idle_ev = tto_arm_q && tick && (tto_cnt_q <= 12'h001);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tto_cnt_q <= 12'h000;
      tto_arm_q <= 1'b0;
    end else if (tx_pkt_start) begin
      tto_arm_q <= 1'b0;
    end else if (tx_pkt_end) begin
      tto_cnt_q <= tx_tto_q;
      tto_arm_q <= tx_idle_irq_enable_q;
    end else if (tx_idle_ev) begin
      tto_cnt_q <= 12'h000;
      tto_arm_q <= 1'b0;
    end else if (tto_arm_q && tick) begin
      tto_cnt_q <= tto_cnt_q - 12'h001;
    end
  end

  // rom port register
  assign start_rd = wr_c && hit(wb_adr_i, ppt_pkg::OFF_ROM) && !fl_busy && !ren_q && !wen_q
                    && wmask[ppt_pkg::ROM_REN_BIT] && wd[ppt_pkg::ROM_REN_BIT];
  assign start_wr = wr_c && hit(wb_adr_i, ppt_pkg::OFF_ROM) && !fl_busy && !ren_q && !wen_q
                    && wmask[ppt_pkg::ROM_WEN_BIT] && wd[ppt_pkg::ROM_WEN_BIT] && !wd[ppt_pkg::ROM_REN_BIT];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      a16_sel_q  <= ppt_pkg::ROM_A16_RESET;
      ren_q      <= 1'b0;
      wen_q      <= 1'b0;
      rom_addr_q <= 17'h00000;
      rom_wdat_q <= 8'h00;
    end else begin
      if (wr_c && hit(wb_adr_i, ppt_pkg::OFF_ROM) && !ren_q && !wen_q) begin
        if (wmask[ppt_pkg::ROM_A16_BIT]) begin
          a16_sel_q <= wd[ppt_pkg::ROM_A16_BIT];
        end
        rom_addr_q <= (rom_addr_q & ~wmask[ppt_pkg::ROM_ADDR_LSB +: 17]) | wd[ppt_pkg::ROM_ADDR_LSB +: 17];
        rom_wdat_q <= (rom_wdat_q & ~wmask[ppt_pkg::ROM_DATA_LSB +: 8]) | wd[ppt_pkg::ROM_DATA_LSB +: 8];
      end
      // one data byte: holds the write byte until a read returns
      if (fl_done && ren_q) begin
        rom_wdat_q <= fl_rdata;
      end
      if (start_rd) begin
        ren_q <= 1'b1;
      end else if (fl_done) begin
        ren_q <= 1'b0;
      end
      if (start_wr) begin
        wen_q <= 1'b1;
      end else if (fl_done) begin
        wen_q <= 1'b0;
      end
    end
  end

  ppt_flash_port #(
    .ACC_CYC (ppt_pkg::ROM_ACC_CYC)
  ) u_flash (
    .mclk            (mclk),
    .arst_n          (arst_n),
    .start_rd        (start_rd),
    .start_wr        (start_wr),
    .addr            ((rom_addr_q & ~wmask[ppt_pkg::ROM_ADDR_LSB +: 17]) | wd[ppt_pkg::ROM_ADDR_LSB +: 17]),
    .wdata           ((rom_wdat_q & ~wmask[ppt_pkg::ROM_DATA_LSB +: 8]) | wd[ppt_pkg::ROM_DATA_LSB +: 8]),
    .busy            (fl_busy),
    .done            (fl_done),
    .rdata_q         (fl_rdata),
    .rom_addr_o      (rom_addr_o),
    .rom_ce_n_o      (rom_ce_n_o),
    .rom_oe_n_o      (rom_oe_n_o),
    .rom_we_n_o      (rom_we_n_o),
    .rom_data_i      (rom_data_i),
    .rom_data_o      (rom_data_o),
    .rom_data_oe_n_o (rom_data_oe_n_o)
  );

  // four-led strap synchroniser
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      led_s1_q <= 1'b0;
      led_s2_q <= 1'b0;
    end else begin
      led_s1_q <= four_led_select;
      led_s2_q <= led_s1_q;
    end
  end

  assign shared_pin_o = (led_s2_q && a16_sel_q) ? rom_addr_o[16] : led_fd_col;

  // interrupt status, write one to clear, set wins
  always_comb begin
    irq_set = '0;
    irq_set[ppt_pkg::IRQ_WAKE]     = wake_event;
    irq_set[ppt_pkg::IRQ_TX_DONE]  = tx_done_ev;
    irq_set[ppt_pkg::IRQ_TX_IDLE]  = tx_idle_ev;
    irq_set[ppt_pkg::IRQ_ROM_DONE] = fl_done;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= '0;
    end else if (wr_c && hit(wb_adr_i, ppt_pkg::OFF_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~wd[IRQ_N_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_q <= '0;
    end else if (wr_c && hit(wb_adr_i, ppt_pkg::OFF_IRQ_MASK) && wb_sel_i[0]) begin
      irq_mask_q <= wb_dat_i[IRQ_N_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule : ppt_csr_bank

// *** dv/ppt_flash_model.sv ***
// behavioural byte-wide flash seen by the rom port pins
`timescale 1ns/1ps
module ppt_flash_model #(
  parameter int RD_DLY = 0
) (
  // flash pins
  input  wire logic [16:0] rom_addr_o,
  input  wire logic        rom_ce_n_o,
  input  wire logic        rom_oe_n_o,
  input  wire logic        rom_we_n_o,
  input  wire logic [7:0]  rom_data_o,
  input  wire logic        rom_data_oe_n_o,
  output logic [7:0]       rom_data_i
);
  logic [7:0] mem [logic [16:0]];
  logic [7:0] last;
  logic [7:0] val;
  logic       drv;
  // byte is stored at the end of the write strobe
  always @(posedge rom_we_n_o) begin
    if (!rom_ce_n_o && !rom_data_oe_n_o) mem[rom_addr_o] = rom_data_o;
  end
  assign drv = !rom_ce_n_o && !rom_oe_n_o;
  assign val = mem.exists(rom_addr_o) ? mem[rom_addr_o] : 8'hff;
  always @(drv, val) begin
    if (drv) last = val;
  end
  // released bus shows the inverse of the last byte
  assign #(RD_DLY) rom_data_i = drv ? val : ~last;
endmodule : ppt_flash_model

// *** dv/ppt_csr_bank_monitor.sv ***
// port assertions for the ppt register bank
`timescale 1ns/1ps
module ppt_csr_bank_monitor (
  // clock, reset, bus
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // power and led pins
  input wire logic        pme_o,
  input wire logic [1:0]  power_state_o,
  input wire logic        four_led_select,
  input wire logic        led_fd_col,
  input wire logic        shared_pin_o,
  // flash pins
  input wire logic [16:0] rom_addr_o,
  input wire logic        rom_ce_n_o,
  input wire logic        rom_oe_n_o,
  input wire logic        rom_we_n_o,
  input wire logic        rom_data_oe_n_o
);
  localparam int STRB_CYC = ppt_pkg::ROM_ACC_CYC;
  logic       strb;
  logic [7:0] strb_cnt_q;
  assign strb = !rom_oe_n_o || !rom_we_n_o;
  // length of the current strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) strb_cnt_q <= 8'h00;
    else if (strb) strb_cnt_q <= strb_cnt_q + 8'h01;
    else strb_cnt_q <= 8'h00;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence setup_s; rom_oe_n_o && rom_we_n_o; endsequence
  sequence strobe_s; strb; endsequence
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_stray_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  strobe_len_a: assert property ($fell(strb) |-> strb_cnt_q == 8'(STRB_CYC))
    else $error("flash strobe length wrong");
  strobe_setup_a: assert property ($fell(rom_ce_n_o) |-> setup_s ##[1:4] strobe_s)
    else $error("no strobe after chip enable");
  addr_stable_a: assert property (strb && $past(strb) |-> $stable(rom_addr_o))
    else $error("flash address moved in strobe");
  strobe_ce_a: assert property (strb |-> !rom_ce_n_o)
    else $error("strobe without chip enable");
  one_dir_a: assert property (!(!rom_oe_n_o && !rom_we_n_o))
    else $error("read and write strobes together");
  wdata_drive_a: assert property (!rom_we_n_o |-> !rom_data_oe_n_o)
    else $error("write strobe without data drive");
  rd_release_a: assert property (!rom_oe_n_o |-> rom_data_oe_n_o)
    else $error("data driven during read");
  pme_level_a: assert property (pme_o == 1'b0)
    else $error("wake pin driven high");
  power_legal_a: assert property (power_state_o == 2'h0 || power_state_o == 2'h3)
    else $error("unsupported power state taken");
  led_route_a: assert property (!four_led_select [*4] |-> shared_pin_o == led_fd_col)
    else $error("shared pin not on led");
endmodule : ppt_csr_bank_monitor

// *** dv/ppt_csr_bank_tb.sv ***
// self-checking bench for the ppt register bank
`timescale 1ns/1ps
module ppt_csr_bank_tb;
  logic        mclk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, bm_rd_pending, speed_100, four_led_select, led_fd_col;
  logic        bm_dword, wake_event, tx_burst_ok, tx_burst_fail, tx_pkt_start, tx_pkt_end;
  logic        pme_o, pme_oe_n_o, shared_pin_o, rom_ce_n_o, rom_oe_n_o, rom_we_n_o, rom_data_oe_n_o, irq_o, wb_ack_o;
  logic [1:0]  power_state_o;
  logic [3:0]  wb_sel_i;
  logic [5:0]  ev;
  logic [7:0]  wb_adr_i, rom_data_i, rom_data_o;
  logic [16:0] rom_addr_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          n_errors, num_checks;
  assign {tx_pkt_end, tx_pkt_start, tx_burst_fail, tx_burst_ok, wake_event, bm_dword} = ev;
  ppt_csr_bank dut (.*);
  ppt_flash_model u_flash (.*);
  always #5 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      ev[b] <= 1'b1;
      @(posedge mclk);
      ev[b] <= 1'b0;
      @(posedge mclk);
    end
  endtask : pulse
  task automatic rom_wait;
    for (int i = 0; i < 60; i++) begin
      wb(ppt_pkg::OFF_ROM, 1'b0, 32'h0);
      if (rd[27:26] === 2'b00) break;
    end
  endtask : rom_wait
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
  initial begin
    {mclk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, bm_rd_pending, four_led_select, led_fd_col} = 8'h00;
    {ev, wb_adr_i, wb_dat_i, n_errors, num_checks} = '0;
    wb_sel_i = 4'hf;
    speed_100 = 1'b1;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rdc(ppt_pkg::OFF_PERF, 32'h0);
    rdc(ppt_pkg::OFF_TXBR, 32'h0);
    rdc(ppt_pkg::OFF_ROM, 32'h8000_0000);
    rdc(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 32'h0);
    rdc(8'h10, 32'h0);
    $display("reset test done");
    bm_rd_pending <= 1'b1;
    repeat (10) @(posedge mclk);
    bm_rd_pending <= 1'b0;
    pulse(0, 5);
    rdc(ppt_pkg::OFF_PERF, {16'h000a, 8'h00, 8'h05});
    rdc(ppt_pkg::OFF_PERF, 32'h0);
    $display("perf test done");
    wb(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 1'b1, 32'h0000_7e03);
    rdc(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 32'h3);
    chk({30'h0, power_state_o}, 32'h3);
    wb(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 1'b1, 32'h2);
    rdc(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 32'h3);
    wb(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 1'b1, 32'h0);
    rdc(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 32'h0);
    $display("power test done");
    pulse(1, 1);
    rdc(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 32'h8000);
    chk({31'h0, pme_oe_n_o}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    wb(ppt_pkg::OFF_IRQ_MASK, 1'b1, 32'hf);
    @(posedge mclk);
    chk({31'h0, irq_o}, 32'h1);
    wb(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 1'b1, 32'h100);
    rdc(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 32'h8100);
    chk({31'h0, pme_oe_n_o}, 32'h0);
    wb(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 1'b1, 32'h8100);
    rdc(ppt_pkg::OFF_POWER_MGMT_CTRL_STATUS_MIRROR, 32'h100);
    chk({31'h0, pme_oe_n_o}, 32'h1);
    wb(ppt_pkg::OFF_IRQ_STAT, 1'b1, 32'h1);
    @(posedge mclk);
    chk({31'h0, irq_o}, 32'h0);
    $display("wake test done");
    wb(ppt_pkg::OFF_TXBR, 1'b1, 32'h0003_0002);
    rdc(ppt_pkg::OFF_TXBR, 32'h0003_0002);
    pulse(2, 2);
    pulse(3, 1);
    pulse(2, 2);
    rdc(ppt_pkg::OFF_IRQ_STAT, 32'h0);
    pulse(2, 1);
    rdc(ppt_pkg::OFF_IRQ_STAT, 32'h2);
    wb(ppt_pkg::OFF_IRQ_STAT, 1'b1, 32'h2);
    $display("burst test done");
    wb(ppt_pkg::OFF_CTRL, 1'b1, 32'h1);
    pulse(5, 1);
    repeat (200) @(posedge mclk);
    rdc(ppt_pkg::OFF_IRQ_STAT, 32'h0);
    repeat (330) @(posedge mclk);
    rdc(ppt_pkg::OFF_IRQ_STAT, 32'h4);
    wb(ppt_pkg::OFF_IRQ_STAT, 1'b1, 32'h4);
    pulse(5, 1);
    pulse(4, 1);
    repeat (600) @(posedge mclk);
    rdc(ppt_pkg::OFF_IRQ_STAT, 32'h0);
    $display("idle timer test done");
    four_led_select <= 1'b1;
    led_fd_col <= 1'b0;
    wb(ppt_pkg::OFF_ROM, 1'b1, 32'h8501_2a5c);
    rom_wait();
    chk(rd, 32'h8101_2a5c);
    rdc(ppt_pkg::OFF_IRQ_STAT, 32'h8);
    chk({31'h0, shared_pin_o}, 32'h1);
    wb(ppt_pkg::OFF_ROM, 1'b1, 32'h0901_2a00);
    rom_wait();
    chk(rd, 32'h0101_2a5c);
    chk({31'h0, shared_pin_o}, 32'h0);
    led_fd_col <= 1'b1;
    @(posedge mclk);
    #1;
    chk({31'h0, shared_pin_o}, 32'h1);
    $display("rom test done");
    finish_test();
  end
endmodule : ppt_csr_bank_tb
bind ppt_csr_bank ppt_csr_bank_monitor u_mon (.*);
